/* src/alarm_pkg.sv */
/*
 Shared constants, register map, field layout and carrier types of the
 process alarm evaluator. Assumes a 20 MHz core clock.
*/
package alarm_pkg;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned POWERUP_S = 3;
   localparam int unsigned POWERUP_CYCLES = POWERUP_S * CLK_HZ;

   // ****************************************
   // Register map (byte offsets)
   // ****************************************
   localparam int NUM_ALARMS = 3;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CMD_OFS = 8'h04;
   localparam logic [7:0] SP_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0C;
   localparam logic [1:0] ALM_CFG_W = 2'h0;
   localparam logic [1:0] ALM_X_W = 2'h1;
   localparam logic [1:0] ALM_HL_W = 2'h2;
   localparam logic [1:0] ALM_HYS_W = 2'h3;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_RUN = 0;
   localparam int CTRL_RAMP = 1;
   localparam int CTRL_ANALOG = 2;
   localparam int CTRL_DP = 4;
   localparam int CMD_LCAN = 0;
   localparam int CMD_SRST = 1;
   localparam int CFG_LATCH = 4;
   localparam int CFG_OPEN = 5;
   localparam int CFG_SPSEL = 6;
   localparam int HL_LOWER = 16;
   localparam int STAT_OUT = 3;
   localparam int STAT_SB = 6;
   localparam int STAT_PUP = 9;

   // ****************************************
   // Alarm kinds and reset values
   // ****************************************
   localparam logic [3:0] AK_OFF = 4'h0;
   localparam logic [3:0] AK_DUAL = 4'h1;
   localparam logic [3:0] AK_UP = 4'h2;
   localparam logic [3:0] AK_LO = 4'h3;
   localparam logic [3:0] AK_RANGE = 4'h4;
   localparam logic [3:0] AK_DUAL_SB = 4'h5;
   localparam logic [3:0] AK_UP_SB = 4'h6;
   localparam logic [3:0] AK_LO_SB = 4'h7;
   localparam logic [3:0] AK_ABS_UP = 4'h8;
   localparam logic [3:0] AK_ABS_LO = 4'h9;
   localparam logic [3:0] AK_ABS_UP_SB = 4'hA;
   localparam logic [3:0] AK_ABS_LO_SB = 4'hB;
   localparam logic [3:0] KIND_RST = AK_UP;
   localparam logic [13:0] HYST_RST = 14'h0002;
   localparam logic [13:0] HYST_MIN = 14'h0001;
   localparam logic [13:0] HYST_MAX = 14'h270F;
   localparam logic signed [15:0] VAL_MIN = -16'sd1999;
   localparam logic signed [15:0] VAL_MAX = 16'sd9999;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_DEC = 2'h3;

   typedef struct packed {
      logic [3:0] kind;
      logic latch_en;
      logic open_sel;
      logic sp_sel;
      logic signed [15:0] x;
      logic signed [15:0] h;
      logic signed [15:0] l;
      logic [13:0] hyst;
   } alarm_cfg_t;

   function automatic logic [31:0] merge_strb(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction: merge_strb

   function automatic logic signed [15:0] clamp_val(input logic [15:0] v);
      logic signed [15:0] s;
      s = $signed(v);
      if (s < VAL_MIN) return VAL_MIN;
      if (s > VAL_MAX) return VAL_MAX;
      return s;
   endfunction: clamp_val

   function automatic logic [13:0] clamp_hyst(input logic [13:0] v);
      if (v < HYST_MIN) return HYST_MIN;
      if (v > HYST_MAX) return HYST_MAX;
      return v;
   endfunction: clamp_hyst

   // Hysteresis in process value counts; one decimal forced for integer analog scaling
   function automatic logic [13:0] hyst_counts(input logic [13:0] v,
         input logic analog, input logic [1:0] dp);
      logic [13:0] q;
      q = 14'((v + 14'h0009) / 14'h000A);
      if (analog && dp == 2'h0) return q;
      return v;
   endfunction: hyst_counts

endpackage: alarm_pkg

/* src/powerup_hold.sv */
/*
 Power-up hold-off timer: done rises once CYCLES clocks have passed
 after reset release. Assumes one clock and an asynchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module powerup_hold #(
   parameter int unsigned CYCLES = 60_000_000
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Status
   output logic done
);

   logic [31:0] count;

   // ****************************************
   // Counter
   // ****************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count <= 32'h00000000;
         done <= 1'b0;
      end else if (!done) begin
         count <= count + 32'h00000001;
         done <= (count + 32'h00000001 >= CYCLES);
      end
   end

endmodule: powerup_hold
`default_nettype wire

/* src/process_alarm_evaluator.sv */
/*
 Three-alarm process value evaluator with an AXI4-Lite register slave.
 Assumes pv and ramp_sp come from logic on core_clk; alarm_out drives
 alarm contacts, high meaning closed.
*/
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module process_alarm_evaluator
   import alarm_pkg::*;
#(
   parameter int unsigned POWERUP_CYC = POWERUP_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // AXI4-Lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Process values
   input wire logic signed [15:0] pv,
   input wire logic signed [15:0] ramp_sp,
   // Alarm contacts
   output logic [NUM_ALARMS-1:0] alarm_out
);

   // ****************************************
   // Register state
   // ****************************************
   logic run;
   logic ramp_en;
   logic analog;
   logic [1:0] dp;
   logic signed [15:0] sp;
   alarm_cfg_t cfg [NUM_ALARMS];
   logic run_q;
   logic sp_chg;
   logic srst_cmd;
   logic lcan_cmd;
   logic pup_done;

   // ****************************************
   // Write channel capture
   // ****************************************
   logic aw_full;
   logic w_full;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   wire do_write = aw_full && w_full && !bvalid;
   wire wr_alm = (wr_addr[7:4] >= 4'h1) && (wr_addr[7:4] <= 4'h3);
   wire [1:0] wr_idx = 2'(wr_addr[7:4] - 4'h1);
   wire wr_known = wr_alm || wr_addr[7:2] <= STAT_OFS[7:2];
   wire [31:0] cur_ctrl = {26'h0, dp, 1'b0, analog, ramp_en, run};

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OK;
      end else begin
         if (awvalid && awready) begin
            aw_full <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            w_full <= 1'b1;
            wready <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? RESP_OK : RESP_DEC;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   wire [31:0] ctrl_w = merge_strb(cur_ctrl, wr_data, wr_strb);
   wire [31:0] cmd_w = merge_strb(32'h00000000, wr_data, wr_strb);
   wire [31:0] sp_w = merge_strb({16'h0000, sp}, wr_data, wr_strb);
   wire signed [15:0] sp_new = clamp_val(sp_w[15:0]);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         run <= 1'b0;
         ramp_en <= 1'b0;
         analog <= 1'b0;
         dp <= 2'h0;
         sp <= 16'sh0000;
         sp_chg <= 1'b0;
         srst_cmd <= 1'b0;
         lcan_cmd <= 1'b0;
         run_q <= 1'b0;
      end else begin
         sp_chg <= 1'b0;
         srst_cmd <= 1'b0;
         lcan_cmd <= 1'b0;
         run_q <= run;
         if (do_write && wr_addr == CTRL_OFS) begin
            run <= ctrl_w[CTRL_RUN];
            ramp_en <= ctrl_w[CTRL_RAMP];
            analog <= ctrl_w[CTRL_ANALOG];
            dp <= ctrl_w[CTRL_DP +: 2];
         end
         if (do_write && wr_addr == CMD_OFS) begin
            lcan_cmd <= cmd_w[CMD_LCAN];
            srst_cmd <= cmd_w[CMD_SRST];
         end
         if (do_write && wr_addr == SP_OFS) begin
            sp <= sp_new;
            sp_chg <= (sp_new != sp);
         end
      end
   end

   // Per-alarm parameter writes; kind always writable, latch, open and SP select bits and hysteresis frozen while control runs
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_ALARMS; i++) begin
            cfg[i].kind <= KIND_RST;
            cfg[i].latch_en <= 1'b0;
            cfg[i].open_sel <= 1'b0;
            cfg[i].sp_sel <= 1'b0;
            cfg[i].x <= 16'sh0000;
            cfg[i].h <= 16'sh0000;
            cfg[i].l <= 16'sh0000;
            cfg[i].hyst <= HYST_RST;
         end
      end else if (do_write && wr_alm) begin
         unique case (wr_addr[3:2])
            ALM_CFG_W: begin
               if (wr_strb[0] && wr_data[3:0] <= AK_ABS_LO_SB) begin
                  cfg[wr_idx].kind <= wr_data[3:0];
               end
               if (wr_strb[0] && !run) begin
                  cfg[wr_idx].latch_en <= wr_data[CFG_LATCH];
                  cfg[wr_idx].open_sel <= wr_data[CFG_OPEN];
                  cfg[wr_idx].sp_sel <= wr_data[CFG_SPSEL];
               end
            end
            ALM_X_W: begin
               cfg[wr_idx].x <= clamp_val(16'(merge_strb({16'h0000, cfg[wr_idx].x},
                  wr_data, wr_strb)));
            end
            ALM_HL_W: begin
               cfg[wr_idx].h <= clamp_val(16'(merge_strb({cfg[wr_idx].l, cfg[wr_idx].h},
                  wr_data, wr_strb)));
               cfg[wr_idx].l <= clamp_val(16'(merge_strb({cfg[wr_idx].l,
                  cfg[wr_idx].h}, wr_data, wr_strb) >> HL_LOWER));
            end
            ALM_HYS_W: begin
               if (!run) begin
                  cfg[wr_idx].hyst <= clamp_hyst(14'(merge_strb(
                     {18'h00000, cfg[wr_idx].hyst}, wr_data, wr_strb)));
               end
            end
         endcase
      end
   end

   // ****************************************
   // Events
   // ****************************************
   wire run_rise = run && !run_q;
   // Software reset also restarts standby; power-on is covered by reset
   wire rearm = run_rise || sp_chg || srst_cmd;
   wire latch_clr = lcan_cmd || srst_cmd;

   powerup_hold #(.CYCLES(POWERUP_CYC)) u_hold (
      .core_clk(core_clk), .rstn(rstn), .done(pup_done)
   );

   // ****************************************
   // Alarm evaluation
   // ****************************************
   logic [NUM_ALARMS-1:0] act;
   logic [NUM_ALARMS-1:0] standby;
   logic [NUM_ALARMS-1:0] latched;
   logic [NUM_ALARMS-1:0] func;

   for (genvar i = 0; i < NUM_ALARMS; i++) begin : g_alm
      wire [3:0] k = cfg[i].kind;
      wire valid = (k != AK_OFF) && (k <= AK_ABS_LO_SB);
      wire is_dual = (k == AK_DUAL) || (k == AK_DUAL_SB);
      wire is_rng = (k == AK_RANGE);
      wire is_up = (k == AK_UP) || (k == AK_UP_SB) || (k == AK_ABS_UP) || (k == AK_ABS_UP_SB);
      wire is_lo = (k == AK_LO) || (k == AK_LO_SB) || (k == AK_ABS_LO) || (k == AK_ABS_LO_SB);
      wire is_abs = (k >= AK_ABS_UP) && (k <= AK_ABS_LO_SB);
      wire is_sb = (k == AK_DUAL_SB) || (k == AK_UP_SB) || (k == AK_LO_SB)
         || (k == AK_ABS_UP_SB) || (k == AK_ABS_LO_SB);
      // Final SP chosen only for deviation kinds under an active ramp
      wire signed [17:0] ref_sp = (ramp_en && !cfg[i].sp_sel) ?
         18'(ramp_sp) : 18'(sp);
      wire signed [17:0] hy = $signed({4'h0, hyst_counts(cfg[i].hyst, analog, dp)});
      wire signed [17:0] up_dev = ref_sp + 18'(cfg[i].x);
      wire signed [17:0] lo_dev = ref_sp - 18'(cfg[i].x);
      wire signed [17:0] up_thr = (is_dual || is_rng) ? ref_sp + 18'(cfg[i].h)
         : (is_abs ? 18'(cfg[i].x) : up_dev);
      wire signed [17:0] lo_thr = (is_dual || is_rng) ? ref_sp - 18'(cfg[i].l)
         : (is_abs ? 18'(cfg[i].x) : lo_dev);
      wire signed [17:0] pvx = 18'(pv);
      wire up_in = pvx > up_thr;
      wire up_stay = pvx > up_thr - hy;
      wire lo_in = pvx < lo_thr;
      wire lo_stay = pvx < lo_thr + hy;
      wire rng_in = (pvx >= lo_thr) && (pvx <= up_thr);
      wire rng_stay = (pvx >= lo_thr - hy) && (pvx <= up_thr + hy);
      wire enter = (is_up && up_in) || (is_lo && lo_in)
         || (is_dual && (up_in || lo_in)) || (is_rng && rng_in);
      wire stay = (is_up && up_stay) || (is_lo && lo_stay)
         || (is_dual && (up_stay || lo_stay)) || (is_rng && rng_stay);
      wire cond = act[i] ? stay : enter;
      wire inverted = (k == AK_DUAL_SB) && (up_thr <= lo_thr);
      wire overlap = (k == AK_DUAL_SB) && (up_thr - lo_thr <= hy);
      wire blocked = !valid || inverted || overlap;
      wire asserted = act[i] && !standby[i] && !blocked;

      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            act[i] <= 1'b0;
            standby[i] <= 1'b1;
            latched[i] <= 1'b0;
            func[i] <= 1'b0;
         end else begin
            act[i] <= valid && cond;
            if (rearm && is_sb) begin
               standby[i] <= 1'b1;
            end else if (!is_sb || !cond) begin
               standby[i] <= 1'b0;
            end
            // A condition still present re-latches over a cancel
            if (cfg[i].latch_en && asserted) begin
               latched[i] <= 1'b1;
            end else if (latch_clr || !valid) begin
               latched[i] <= 1'b0;
            end
            func[i] <= asserted || (latched[i] && valid && !latch_clr);
         end
      end
   end

   // ****************************************
   // Contact drive
   // ****************************************
   logic [NUM_ALARMS-1:0] pol;
   always_comb begin
      for (int i = 0; i < NUM_ALARMS; i++) begin
         pol[i] = func[i] ^ cfg[i].open_sel;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         alarm_out <= '0;
      end else begin
         alarm_out <= pup_done ? pol : '0;
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   wire rd_alm = (araddr[7:4] >= 4'h1) && (araddr[7:4] <= 4'h3);
   wire [1:0] rd_idx = 2'(araddr[7:4] - 4'h1);
   wire rd_known = rd_alm || araddr[7:2] <= STAT_OFS[7:2];
   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h00000000;
      if (rd_alm) begin
         unique case (araddr[3:2])
            ALM_CFG_W: rd_mux = {25'h0, cfg[rd_idx].sp_sel,
               cfg[rd_idx].open_sel, cfg[rd_idx].latch_en, cfg[rd_idx].kind};
            ALM_X_W: rd_mux = 32'(cfg[rd_idx].x);
            ALM_HL_W: rd_mux = {cfg[rd_idx].l, cfg[rd_idx].h};
            ALM_HYS_W: rd_mux = {18'h00000, cfg[rd_idx].hyst};
         endcase
      end else if (araddr == CTRL_OFS) begin
         rd_mux = cur_ctrl;
      end else if (araddr == SP_OFS) begin
         rd_mux = 32'(sp);
      end else if (araddr == STAT_OFS) begin
         rd_mux = {22'h0, pup_done, standby, alarm_out, func};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OK;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= rd_known ? RESP_OK : RESP_DEC;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

endmodule: process_alarm_evaluator
`default_nettype wire

/* sim/process_alarm_evaluator_sva.sv */
/*
 Bus and power-up checker for the process alarm evaluator.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module process_alarm_evaluator_sva
   import alarm_pkg::*;
#(
   parameter int unsigned POWERUP_CYC = POWERUP_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   // Contacts
   input wire logic [NUM_ALARMS-1:0] alarm_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // Saturating count of edges since reset release
   logic [31:0] pup_cnt;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) pup_cnt <= '0;
      else if (pup_cnt < POWERUP_CYC) pup_cnt <= pup_cnt + 32'h1;
   end
   // ****************************************
   // Assertions
   // ****************************************
   power_hold_a: assert property (pup_cnt < POWERUP_CYC |-> alarm_out == '0)
      else $error("alarm contact closed during power-up hold");
   wr_latency_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write response not two edges after take");
   aw_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write channel ready while response pending");
   ready_back_a: assert property (bvalid && bready |=> awready && wready && !bvalid)
      else $error("write channel not reopened after response");
   bresp_legal_a: assert property (bvalid |-> bresp == RESP_OK || bresp == RESP_DEC)
      else $error("illegal write response code");
   rd_latency_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read data not one edge after take");
   rvalid_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed before handshake");
   dec_zero_a: assert property (rvalid && rresp == RESP_DEC |-> rdata == '0)
      else $error("unmapped read returned nonzero data");
   cov_write_c: cover property (bvalid && bready);
   cov_read_c: cover property (rvalid && rready);
   cov_alarm_c: cover property ($rose(alarm_out[0]));
endmodule: process_alarm_evaluator_sva
bind process_alarm_evaluator process_alarm_evaluator_sva #(.POWERUP_CYC(POWERUP_CYC)) chk_u (
   .core_clk(core_clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata), .rresp(rresp), .alarm_out(alarm_out));
`default_nettype wire

/* sim/testbench.sv */
/*
 Self-checking bench for the process alarm evaluator: register access,
 alarm kinds, hysteresis, standby, latch, polarity and set point choice.
 Assumes a shortened power-up hold of 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import alarm_pkg::*;
   localparam int unsigned PUP = 20;
   logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic signed [15:0] pv, ramp_sp, rv;
   logic [NUM_ALARMS-1:0] alarm_out;
   int bad_count, checks;
   typedef struct packed {logic [31:0] m; logic [1:0] r; logic [31:0] d;} exp_t;
   exp_t exp_q[$];
   exp_t mon_e;
   logic [3:0] kinds [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9};
   logic f_hi [6] = '{0, 1, 1, 0, 1, 0};
   logic f_lo [6] = '{0, 1, 0, 1, 0, 1};

   process_alarm_evaluator #(.POWERUP_CYC(PUP)) dut_u (
      .core_clk(core_clk), .rstn(rstn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .pv(pv), .ramp_sp(ramp_sp), .alarm_out(alarm_out));

   // ****************************************
   // Compare and bus tasks
   // ****************************************
   task automatic chk_bus(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask: chk_bus
   task automatic chk_out(input logic [2:0] e);
      @(negedge core_clk);
      checks++;
      if (alarm_out !== e) begin
         bad_count++;
         $display("ERROR alarm_out expected %b seen %b", e, alarm_out);
      end
   endtask: chk_out
   // Ready is registered, so its value at the falling edge is what the next rising edge sees
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OK);
      logic ta, tw, da, dw, tb;
      logic [1:0] br;
      da = 0;
      dw = 0;
      @(posedge core_clk);
      awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= d; bready <= 1;
      do begin
         @(negedge core_clk);
         ta = awvalid && awready && !da;
         tw = wvalid && wready && !dw;
         @(posedge core_clk);
         if (ta) awvalid <= 0;
         if (tw) wvalid <= 0;
         da = da | ta;
         dw = dw | tw;
      end while (!(da && dw));
      do begin
         @(negedge core_clk);
         tb = bvalid;
         br = bresp;
         @(posedge core_clk);
      end while (!tb);
      bready <= 0;
      chk_bus("bresp", 32'(er), 32'(br));
   endtask: wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
         input logic [1:0] r = RESP_OK);
      logic t;
      exp_q.push_back('{m: m, r: r, d: e});
      @(posedge core_clk);
      arvalid <= 1; araddr <= a; rready <= 1;
      do begin @(negedge core_clk); t = arready; @(posedge core_clk); end while (!t);
      arvalid <= 0;
      do begin @(negedge core_clk); t = rvalid; @(posedge core_clk); end while (!t);
      rready <= 0;
   endtask: rd
   task automatic set_reg(input logic [3:0] o, input logic [31:0] v);
      for (int i = 1; i <= 3; i++) wr(8'(i * 16 + int'(o)), v);
   endtask: set_reg
   // Alarm 2 always runs open in alarm so polarity is seen beside closed contacts
   task automatic set_cfg(input logic [6:0] c);
      for (int i = 1; i <= 3; i++) wr(8'(i * 16), {25'h0, (i == 2) ? (c | 7'h20) : c});
   endtask: set_cfg
   task automatic pvc(input logic signed [15:0] v, input logic f);
      @(posedge core_clk);
      pv <= v;
      repeat (4) @(posedge core_clk);
      chk_out({f, ~f, f});
   endtask: pvc
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask: wrap_up

   always @(posedge core_clk) begin
      if (rvalid === 1'b1 && rready === 1'b1) begin
         mon_e = exp_q.pop_front();
         chk_bus("rdata", mon_e.d & mon_e.m, rdata & mon_e.m);
         chk_bus("rresp", 32'(mon_e.r), 32'(rresp));
      end
   end
   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      #(50 * 40000);
      bad_count++;
      wrap_up();
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      rstn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; awprot = 0; arprot = 0; wdata = 0; wstrb = 4'hF;
      pv = 200; ramp_sp = 0; bad_count = 0; checks = 0;
      rv = 16'($urandom(32'h830086e6));
      repeat (10) @(posedge core_clk);
      rstn <= 1;
      rd(STAT_OFS, 32'h0, 32'h200);
      chk_out(3'b000);
      repeat (PUP) @(posedge core_clk);
      rd(STAT_OFS, 32'h200, 32'h200);
      chk_out(3'b111);
      for (int i = 1; i <= 3; i++) begin
         rd(8'(i * 16), 32'h2, 32'h7F);
         rd(8'(i * 16 + 4), 32'h0, 32'hFFFF);
         rd(8'(i * 16 + 8), 32'h0, 32'hFFFFFFFF);
         rd(8'(i * 16 + 12), 32'h2, 32'h3FFF);
      end
      rd(8'h40, 32'h0, 32'hFFFFFFFF, RESP_DEC);
      wr(8'h44, 32'h1, RESP_DEC);
      wr(8'h14, 32'h8000);
      rd(8'h14, 32'hF831, 32'hFFFF);
      wr(8'h14, 32'h4E20);
      rd(8'h14, 32'h270F, 32'hFFFF);
      rv = 16'($urandom_range(11998)) - 16'sd1999;
      wr(8'h18, {rv, rv});
      rd(8'h18, {rv, rv}, 32'hFFFFFFFF);
      wr(8'h1C, 32'h0);
      rd(8'h1C, 32'h1, 32'h3FFF);
      wr(8'h1C, 32'h3FFF);
      rd(8'h1C, 32'h270F, 32'h3FFF);
      wr(8'h10, 32'hC);
      rd(8'h10, 32'h2, 32'hF);
      wr(SP_OFS, 32'd100);
      set_reg(4'h4, 32'd10);
      set_reg(4'h8, {16'd10, 16'd10});
      set_reg(4'hC, 32'd1);
      for (int k = 0; k < 6; k++) begin
         set_cfg({3'b000, kinds[k]});
         pvc(200, f_hi[k]);
         pvc(0, f_lo[k]);
      end
      set_reg(4'hC, 32'd30);
      set_cfg(7'h02);
      pvc(120, 1);
      pvc(100, 1);
      wr(CTRL_OFS, 32'h4);
      pvc(120, 1);
      pvc(100, 0);
      wr(CTRL_OFS, 32'h0);
      set_reg(4'hC, 32'd1);
      // Running: kind still writable, latch and hysteresis frozen
      wr(CTRL_OFS, 32'h1);
      wr(8'h10, 32'h13);
      rd(8'h10, 32'h3, 32'h7F);
      wr(8'h1C, 32'd5);
      rd(8'h1C, 32'h1, 32'h3FFF);
      wr(CTRL_OFS, 32'h0);
      set_cfg(7'h12);
      pvc(200, 1);
      pvc(0, 1);
      wr(CMD_OFS, 32'h1);
      pvc(0, 0);
      pvc(200, 1);
      pvc(0, 1);
      wr(CMD_OFS, 32'h2);
      pvc(0, 0);
      set_cfg(7'h07);
      wr(SP_OFS, 32'd101);
      rd(STAT_OFS, 32'h1C0, 32'h1C0);
      pvc(0, 0);
      pvc(200, 0);
      pvc(0, 1);
      pvc(200, 0);
      pvc(0, 1);
      wr(SP_OFS, 32'd100);
      wr(CTRL_OFS, 32'h2);
      set_cfg(7'h02);
      pvc(50, 1);
      set_cfg(7'h42);
      pvc(50, 0);
      set_cfg(7'h02);
      wr(CTRL_OFS, 32'h0);
      pvc(50, 0);
      wr(CTRL_OFS, 32'h2);
      set_cfg(7'h48);
      pvc(50, 1);
      wr(CTRL_OFS, 32'h0);
      set_cfg(7'h04);
      pvc(100, 1);
      pvc(200, 0);
      set_cfg(7'h05);
      pvc(100, 0);
      pvc(200, 1);
      set_reg(4'hC, 32'd30);
      pvc(200, 0);
      set_reg(4'hC, 32'd1);
      set_reg(4'h8, 32'hFFECFFEC);
      pvc(200, 0);
      wrap_up();
   end
endmodule: testbench
`default_nettype wire
